/* File: include/hdlc_regs_defines.svh */
// Register offsets, field positions and timing constants of the HDLC register block
`ifndef HDLC_REGS_DEFINES_SVH
`define HDLC_REGS_DEFINES_SVH
`define OFS_TIMER 8'h23
`define OFS_TXA1 8'h24
`define OFS_TXA2 8'h25
`define OFS_RXH1 8'h26
`define OFS_RXH2 8'h27
`define OFS_RXL1 8'h28
`define OFS_RXL2 8'h29
`define OFS_TXCL 8'h2a
`define OFS_TXCH 8'h2b
`define OFS_RXCL 8'h2a
`define OFS_RXCH 8'h2b
`define OFS_MODE 8'h30
`define OFS_MASKH 8'h31
`define OFS_MASKL 8'h32
`define OFS_CMD 8'h33
`define OFS_STAT 8'h34
`define RES_HI_CYC 16'h8000
`define RES_LO_CYC 16'h0200
`define XTAL_DIV 2'h3
`define CR_BIT 1
`define CRI_BIT 1
`define MAX_LEN 12'hfff
`endif

/* File: include/hdlc_regs_pkg.sv */
// Types of the HDLC register block
package hdlc_regs_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_ADDRH, RX_ADDRL, RX_CTRL} rxPhase_t;
  typedef enum logic [1:0] {TX_IDLE, TX_ADDRH, TX_ADDRL, TX_DATA} txPhase_t;
  typedef struct packed {
    logic [7:0] adr;
    logic [7:0] dat;
    logic we;
    logic req;
  } wbReq_t;
  typedef struct packed {
    logic [7:0] timerSet;
    logic [7:0] txA1;
    logic [7:0] txA2;
    logic [7:0] rxH1;
    logic [7:0] rxH2;
    logic [7:0] rxL1;
    logic [7:0] rxL2;
    logic [7:0] maskH;
    logic [7:0] maskL;
    logic [7:0] ctrl;
    logic [11:0] txCount;
    logic [7:0] mode;
    logic [11:0] rxCount;
    logic rxOvf;
    logic rxCr;
    logic addrMatch;
    logic [4:0] fifoLevel;
    rxPhase_t rxPh;
    txPhase_t txPh;
    logic txCmd;
    logic [11:0] dmaLeft;
    logic dmaReq;
    logic [7:0] txByte;
    logic txValid;
    logic [15:0] kCnt;
    logic [4:0] tCnt;
    logic [1:0] divCnt;
    logic tick;
    logic tmrExp;
    logic [7:0] rdat;
    logic ack;
    logic [2:0] txcS;
    logic [1:0] rxvS;
  } state_t;
endpackage

/* File: design/hdlc_address_timer_count_regs.sv */
// HDLC address, timer, control-field and byte-count logic with Wishbone slave
// Behaviour
// - Timer period is factor times value-plus-one timer clock periods
// - Factor is 32768 cycles with resolution bit 0, 512 with bit 1
// - Without master clock mode timer clock is the transmit clock
// - Master clock mode uses crystal clock, or crystal divided by 4
// - Auto-mode prepends transmit address bytes, high then low with two bytes
// - Two-byte mode drives high byte bit 1 as command/response per interpretation
// - One-byte mode sends first register for commands, second for responses
// - Transmit address registers used only in auto-mode
// - Received high address byte compared against both high registers
// - Masked address bits are excluded from comparison
// - Received command/response reported per interpretation bit
// - Low registers are low bytes, or command and response addresses
// - Transparent mode 1 reads byte after high address; writes ignored
// - Transparent mode 0 reads first byte after opening flag
// - Extended transparent reads current byte assembled from data pin
// - Last control field is readable and pushed to receive FIFO
// - Twelve-bit receive length; low five bits give FIFO fill
// - In DMA mode frame length is transmit count plus one
// - Transmit command issues that many DMA requests; count 4095 wraps and issues none
// - Overflow flag set when received frame exceeds 4095 bytes
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hdlc_regs_defines.svh"
module hdlc_address_timer_count_regs
  import hdlc_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic txClk,
  input wire logic rxData,
  input wire logic rxBitValid,
  input wire logic rxFlag,
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  input wire logic rxFrameEnd,
  input wire logic fifoPop,
  input wire logic txByteTaken,
  input wire logic dmaAck,
  output logic dmaReq,
  output logic [7:0] txByte,
  output logic txByteValid,
  output logic fifoPush,
  output logic [7:0] fifoData,
  output logic timerExpired
);
  // mode bits: 0 auto, 1 two-byte, 2 master clock, 3 crystal/4, 4 resolution,
  // 5 DMA, 7:6 transparent sub-mode (0 none,1 tr0,2 tr1,3 extended)
  state_t s_q, s_d;
  logic [2:0] rxBits_q, rxBits_d;
  logic [7:0] rxShift_q, rxShift_d;
  logic push_q, push_d;
  logic [7:0] pushDat_q, pushDat_d;
  // Data pin synchronised alongside the bit strobe so both stay aligned
  logic [1:0] rxdS_q, rxdS_d;

  function automatic logic addrHit(input logic [7:0] rx, input logic [7:0] ref_v,
                                   input logic [7:0] msk);
    addrHit = ((rx ^ ref_v) & ~msk) == 8'h00;
  endfunction

  wire logic wbHit = wb_cyc_i & wb_stb_i & ~s_q.ack;
  wire logic txClkRise = s_q.txcS[2] ^ s_q.txcS[1] ? s_q.txcS[1] : 1'b0;
  wire logic rxvRise = s_q.rxvS[1];

  always_comb begin
    logic [15:0] kLim;
    logic cmdFrame;
    kLim = 16'h0000;
    cmdFrame = 1'b0;
    s_d = s_q;
    rxBits_d = rxBits_q;
    rxShift_d = rxShift_q;
    push_d = 1'b0;
    pushDat_d = pushDat_q;
    rxdS_d = {rxdS_q[0], rxData};
    s_d.txcS = {s_q.txcS[1:0], txClk};
    s_d.rxvS = {s_q.rxvS[0], rxBitValid};
    s_d.tmrExp = 1'b0;
    // Timer clock source select
    if (s_q.mode[2]) begin
      if (s_q.mode[3]) begin
        s_d.divCnt = s_q.divCnt + 2'h1;
        s_d.tick = (s_q.divCnt == `XTAL_DIV);
      end else begin
        s_d.tick = 1'b1;
      end
    end else begin
      s_d.tick = txClkRise;
    end
    kLim = s_q.mode[4] ? `RES_LO_CYC : `RES_HI_CYC;
    if (s_q.tick) begin
      // At-or-above compare: a lowered setting must not wrap the counters
      if (s_q.kCnt >= kLim - 16'h0001) begin
        s_d.kCnt = 16'h0000;
        if (s_q.tCnt >= s_q.timerSet[4:0]) begin
          s_d.tCnt = 5'h00;
          s_d.tmrExp = 1'b1;
        end else begin
          s_d.tCnt = s_q.tCnt + 5'h01;
        end
      end else begin
        s_d.kCnt = s_q.kCnt + 16'h0001;
      end
    end
    // Extended transparent: bit assembly from the data pin
    if (s_q.mode[7:6] == 2'h3 && rxvRise) begin
      rxShift_d = {rxShift_q[6:0], rxdS_q[1]};
      rxBits_d = rxBits_q + 3'h1;
      if (rxBits_q == 3'h7) begin
        s_d.rxL1 = {rxShift_q[6:0], rxdS_q[1]};
      end
    end
    // Receive framing path
    if (rxFlag) begin
      s_d.rxPh = RX_ADDRH;
      s_d.rxCount = 12'h000;
      s_d.rxOvf = 1'b0;
      s_d.addrMatch = 1'b0;
    end else if (rxByteValid && s_q.mode[7:6] != 2'h3) begin
      if (s_q.rxCount == `MAX_LEN) begin
        s_d.rxOvf = 1'b1;
      end else begin
        s_d.rxCount = s_q.rxCount + 12'h001;
      end
      if (s_q.fifoLevel != 5'h1f) begin
        s_d.fifoLevel = s_q.fifoLevel + 5'h01;
      end
      case (s_q.rxPh)
        RX_ADDRH: begin
          if (s_q.mode[7:6] == 2'h1) begin
            s_d.rxL1 = rxByte;
            s_d.rxPh = RX_IDLE;
          end else if (s_q.mode[1] || s_q.mode[7:6] == 2'h2) begin
            s_d.addrMatch = addrHit(rxByte & 8'hfd, s_q.rxH1 & 8'hfd, s_q.maskH)
                         | addrHit(rxByte & 8'hfd, s_q.rxH2 & 8'hfd, s_q.maskH);
            s_d.rxCr = rxByte[`CR_BIT] ^ ~s_q.rxH1[`CRI_BIT];
            s_d.rxPh = RX_ADDRL;
          end else begin
            // One-byte: low registers are command and response addresses
            s_d.addrMatch = addrHit(rxByte, s_q.rxL1, s_q.maskL)
                         | addrHit(rxByte, s_q.rxL2, s_q.maskL);
            s_d.rxCr = ~addrHit(rxByte, s_q.rxL1, s_q.maskL) ^ ~s_q.rxH1[`CRI_BIT];
            s_d.rxPh = RX_CTRL;
          end
        end
        RX_ADDRL: begin
          if (s_q.mode[7:6] == 2'h2) begin
            s_d.rxL1 = rxByte;
          end else begin
            s_d.addrMatch = s_q.addrMatch & (addrHit(rxByte, s_q.rxL1, s_q.maskL)
                          | addrHit(rxByte, s_q.rxL2, s_q.maskL));
          end
          s_d.rxPh = RX_CTRL;
        end
        RX_CTRL: begin
          s_d.ctrl = rxByte;
          push_d = 1'b1;
          pushDat_d = rxByte;
          s_d.rxPh = RX_IDLE;
        end
        default: s_d.rxPh = RX_IDLE;
      endcase
    end
    if (fifoPop && s_d.fifoLevel != 5'h00) begin
      s_d.fifoLevel = s_d.fifoLevel - 5'h01;
    end
    if (rxFrameEnd) begin
      s_d.rxPh = RX_IDLE;
    end
    // Transmit address insertion and DMA requests
    if (s_q.txValid && txByteTaken) begin
      s_d.txValid = 1'b0;
    end
    if (s_q.dmaReq && dmaAck) begin
      s_d.dmaReq = 1'b0;
      s_d.dmaLeft = s_q.dmaLeft - 12'h001;
    end
    cmdFrame = s_q.txCmd;
    case (s_q.txPh)
      TX_ADDRH: if (!s_d.txValid) begin
        if (s_q.mode[1]) begin
          s_d.txByte = s_q.txA1;
          s_d.txByte[`CR_BIT] = cmdFrame ~^ s_q.rxH1[`CRI_BIT];
          s_d.txPh = TX_ADDRL;
        end else begin
          s_d.txByte = cmdFrame ? s_q.txA1 : s_q.txA2;
          s_d.txPh = TX_DATA;
        end
        s_d.txValid = 1'b1;
      end
      TX_ADDRL: if (!s_d.txValid) begin
        s_d.txByte = s_q.txA2;
        s_d.txValid = 1'b1;
        s_d.txPh = TX_DATA;
      end
      TX_DATA: begin
        if (!s_q.mode[5] || (s_d.dmaLeft == 12'h000 && !s_q.dmaReq)) begin
          s_d.txPh = TX_IDLE;
        // Low for a cycle between requests, so each one is seen once
        end else if (!s_q.dmaReq && !s_d.dmaReq && s_d.dmaLeft != 12'h000) begin
          s_d.dmaReq = 1'b1;
        end
      end
      default: s_d.txPh = TX_IDLE;
    endcase
    // Bus slave
    s_d.ack = wbHit;
    if (wbHit && wb_we_i) begin
      case (wb_adr_i)
        `OFS_TIMER: s_d.timerSet = wb_dat_i;
        `OFS_TXA1: s_d.txA1 = wb_dat_i;
        `OFS_TXA2: s_d.txA2 = wb_dat_i;
        `OFS_RXH1: s_d.rxH1 = wb_dat_i;
        `OFS_RXH2: s_d.rxH2 = wb_dat_i;
        `OFS_RXL1: if (s_q.mode[7:6] == 2'h0) s_d.rxL1 = wb_dat_i;
        `OFS_RXL2: s_d.rxL2 = wb_dat_i;
        `OFS_TXCL: s_d.txCount[7:0] = wb_dat_i;
        `OFS_TXCH: s_d.txCount[11:8] = wb_dat_i[3:0];
        `OFS_MODE: s_d.mode = wb_dat_i;
        `OFS_MASKH: s_d.maskH = wb_dat_i;
        `OFS_MASKL: s_d.maskL = wb_dat_i;
        `OFS_CMD: if (s_q.txPh == TX_IDLE) begin
          s_d.txCmd = wb_dat_i[1];
          s_d.dmaLeft = s_q.txCount + 12'h001;
          s_d.txPh = s_q.mode[0] ? TX_ADDRH : TX_DATA;
        end
        default: ;
      endcase
    end
    s_d.rdat = 8'h00;
    if (wbHit && !wb_we_i) begin
      case (wb_adr_i)
        `OFS_TIMER: s_d.rdat = s_q.timerSet;
        `OFS_TXA1: s_d.rdat = s_q.txA1;
        `OFS_TXA2: s_d.rdat = s_q.txA2;
        `OFS_RXL1: s_d.rdat = s_q.rxL1;
        `OFS_RXL2: s_d.rdat = s_q.ctrl;
        `OFS_RXCL: s_d.rdat = {s_q.rxCount[7:5], s_q.fifoLevel};
        `OFS_RXCH: s_d.rdat = {3'h0, s_q.rxOvf, s_q.rxCount[11:8]};
        `OFS_MODE: s_d.rdat = s_q.mode;
        `OFS_MASKH: s_d.rdat = s_q.maskH;
        `OFS_MASKL: s_d.rdat = s_q.maskL;
        `OFS_STAT: s_d.rdat = {4'h0, s_q.addrMatch, s_q.rxCr, s_q.txPh != TX_IDLE,
                               s_q.dmaReq};
        default: s_d.rdat = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      rxBits_q <= 3'h0;
      rxShift_q <= 8'h00;
      push_q <= 1'b0;
      pushDat_q <= 8'h00;
      rxdS_q <= 2'h0;
    end else begin
      s_q <= s_d;
      rxBits_q <= rxBits_d;
      rxShift_q <= rxShift_d;
      push_q <= push_d;
      pushDat_q <= pushDat_d;
      rxdS_q <= rxdS_d;
    end
  end

  assign wb_dat_o = s_q.rdat;
  assign wb_ack_o = s_q.ack;
  assign dmaReq = s_q.dmaReq;
  assign txByte = s_q.txByte;
  assign txByteValid = s_q.txValid;
  assign fifoPush = push_q;
  assign fifoData = pushDat_q;
  assign timerExpired = s_q.tmrExp;

  a_ack_one_cycle: assert property (@(posedge mclk) disable iff (!arst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");
  a_ctrl_capture: assert property (@(posedge mclk) disable iff (!arst_n)
    (rxByteValid && !rxFlag && s_q.rxPh == RX_CTRL && s_q.mode[7:6] != 2'h3)
      |=> fifoPush && s_q.ctrl == $past(rxByte))
    else $error("control field not captured");
  a_len_overflow: assert property (@(posedge mclk) disable iff (!arst_n)
    (rxByteValid && !rxFlag && s_q.rxCount == 12'hfff && s_q.mode[7:6] != 2'h3)
      |=> s_q.rxOvf)
    else $error("overflow not flagged");
  a_dma_count: assert property (@(posedge mclk) disable iff (!arst_n)
    (wbHit && wb_we_i && wb_adr_i == `OFS_CMD && s_q.txPh == TX_IDLE)
      |=> s_q.dmaLeft == $past(s_q.txCount) + 12'h001)
    else $error("DMA count not length plus one");
  a_cr_drive: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_q.txPh == TX_ADDRH && !s_d.txValid && s_q.mode[1])
      |=> txByte[1] == (s_q.txCmd ~^ s_q.rxH1[1]))
    else $error("C/R bit wrong");
  a_tr1_nowrite: assert property (@(posedge mclk) disable iff (!arst_n)
    (wbHit && wb_we_i && wb_adr_i == `OFS_RXL1 && s_q.mode[7:6] != 2'h0 &&
     !rxByteValid && !rxvRise) |=> $stable(s_q.rxL1))
    else $error("transparent register written");
  a_timer_master: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_q.mode[2] && !s_q.mode[3] && $past(s_q.mode[2] && !s_q.mode[3])) |-> s_q.tick)
    else $error("crystal tick missing");
  a_dma_stop: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_q.dmaLeft == 12'h000) |-> !(s_d.dmaReq && !s_q.dmaReq))
    else $error("extra DMA request");
endmodule
`default_nettype wire

/* File: sim/remote_station.sv */
// Far station model: takes address bytes, acknowledges DMA, sends frames
`timescale 1ns/1ps
`default_nettype none
module remote_station (
  input wire logic mclk,
  input wire logic dmaReq,
  input wire logic txByteValid,
  input wire logic [7:0] txByte,
  output logic txByteTaken,
  output logic dmaAck,
  output logic rxFlag,
  output logic rxByteValid,
  output logic [7:0] rxByte,
  output logic rxFrameEnd
);
  logic [7:0] got[$];
  int dmaCount = 0;
  int stall = 0;
  initial {txByteTaken, dmaAck, rxFlag, rxByteValid, rxFrameEnd, rxByte} = '0;
  // Stall lets the sender hold its byte for a while
  always begin
    @(posedge mclk);
    if (txByteValid === 1'b1) begin
      repeat (stall) @(posedge mclk);
      got.push_back(txByte);
      txByteTaken <= 1'b1;
      @(posedge mclk);
      txByteTaken <= 1'b0;
    end
  end
  // Extra idle edge so one request is never counted twice
  always begin
    @(posedge mclk);
    if (dmaReq === 1'b1) begin
      dmaCount++;
      dmaAck <= 1'b1;
      @(posedge mclk);
      dmaAck <= 1'b0;
      @(posedge mclk);
    end
  end
  // Released byte lines show the inverse, never the last value
  task automatic frame(input logic [23:0] b);
    rxFlag <= 1'b1;
    for (int i = 2; i >= 0; i--) begin
      @(posedge mclk);
      rxFlag <= 1'b0;
      rxByteValid <= 1'b1;
      rxByte <= b[i*8 +: 8];
      @(posedge mclk);
      rxByteValid <= 1'b0;
      rxByte <= ~b[i*8 +: 8];
    end
    rxFrameEnd <= 1'b1;
    @(posedge mclk);
    rxFrameEnd <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench of the HDLC address, timer and count registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hdlc_regs_pkg::*;
  typedef struct packed {logic [7:0] adr; logic [7:0] wd; logic [7:0] rd;} row_t;
  logic mclk, arst_n, wbCyc, wbStb, wbWe, wbAck, txClk, txByteTaken, dmaAck, dmaReq;
  logic rxFlag, rxByteValid, rxFrameEnd, txByteValid, fifoPush, timerExpired;
  logic [7:0] wbAdr, wbDat, wbDatO, rxByte, txByte, fifoData, q;
  logic [7:0] lastCtrl = 8'h00;
  logic rxD = 1'b0;
  logic rxBv = 1'b0;
  logic [7:0] extByte = 8'ha5;
  int fails = 0;
  int compares = 0;
  int n, g;
  row_t rows[4] = '{'{8'h23, 8'h95, 8'h95}, '{8'h24, 8'h40, 8'h40},
    '{8'h25, 8'h5b, 8'h5b}, '{8'h40, 8'h77, 8'h00}};
  logic [39:0] tx[7] = '{40'h03_02_02_42_5b, 40'h03_02_00_40_5b, 40'h03_00_02_40_5b,
    40'h03_00_00_42_5b, 40'h01_00_02_40_00, 40'h01_00_00_5b_00, 40'h00_00_02_00_00};
  logic [11:0] cnt[2] = '{12'h000, 12'h005};
  logic [23:0] rx[4] = '{24'h10_00_01, 24'h14_00_00, 24'h14_04_01, 24'h20_00_01};
  logic [31:0] tm[4] = '{32'h14_00_0200, 32'h14_01_0400, 32'h1c_00_0800, 32'h10_00_1000};

  hdlc_address_timer_count_regs hdlc_address_timer_count_regs_inst (.mclk(mclk),
    .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .txClk(txClk), .rxData(rxD),
    .rxBitValid(rxBv), .rxFlag(rxFlag), .rxByteValid(rxByteValid), .rxByte(rxByte),
    .rxFrameEnd(rxFrameEnd), .fifoPop(1'b0), .txByteTaken(txByteTaken), .dmaAck(dmaAck),
    .dmaReq(dmaReq), .txByte(txByte), .txByteValid(txByteValid), .fifoPush(fifoPush),
    .fifoData(fifoData), .timerExpired(timerExpired));
  remote_station remote_station_inst (.mclk(mclk), .dmaReq(dmaReq),
    .txByteValid(txByteValid), .txByte(txByte), .txByteTaken(txByteTaken), .dmaAck(dmaAck),
    .rxFlag(rxFlag), .rxByteValid(rxByteValid), .rxByte(rxByte), .rxFrameEnd(rxFrameEnd));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Transmit clock of eight system cycles, out of phase with mclk
  initial begin
    txClk = 1'b0;
    forever #20 txClk = ~txClk;
  end
  always @(posedge mclk) if (fifoPush === 1'b1) lastCtrl <= fifoData;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDat <= d;
    do begin
      @(posedge mclk);
      k++;
    end while (wbAck !== 1'b1 && k < 50);
    q = wbDatO;
    if (wbAck !== 1'b1) fails++;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge mclk);
  endtask
  // First pulse may be partial, so the second spacing is measured
  task automatic gap(output int c);
    repeat (2) begin
      c = 0;
      do begin
        @(posedge mclk);
        c++;
      end while (timerExpired !== 1'b1 && c < 9000);
    end
  endtask
  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {wbCyc, wbStb, wbWe, wbAdr, wbDat} = '0;
    arst_n = 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    chk({wbAck, dmaReq, txByteValid, fifoPush, timerExpired}, 16'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].adr, rows[i].wd);
      bus(1'b0, rows[i].adr, 8'h00);
      chk(q, rows[i].rd);
    end
    $display("registers done");
    foreach (tx[i]) begin
      remote_station_inst.got.delete();
      remote_station_inst.stall = i % 3;
      bus(1'b1, 8'h30, tx[i][39:32]);
      bus(1'b1, 8'h26, tx[i][31:24]);
      bus(1'b1, 8'h33, tx[i][23:16]);
      repeat (40) @(posedge mclk);
      n = tx[i][32] ? (tx[i][33] ? 2 : 1) : 0;
      chk(16'(remote_station_inst.got.size()), 16'(n));
      for (int k = 0; k < n; k++) chk(remote_station_inst.got[k], tx[i][15-8*k -: 8]);
    end
    $display("address insertion done");
    foreach (cnt[i]) begin
      remote_station_inst.dmaCount = 0;
      bus(1'b1, 8'h30, 8'h20);
      bus(1'b1, 8'h2a, cnt[i][7:0]);
      bus(1'b1, 8'h2b, {4'h0, cnt[i][11:8]});
      bus(1'b1, 8'h33, 8'h02);
      repeat (80) @(posedge mclk);
      chk(16'(remote_station_inst.dmaCount), {4'h0, cnt[i]} + 16'h1);
    end
    $display("dma count done");
    bus(1'b1, 8'h30, 8'h02);
    bus(1'b1, 8'h26, 8'h10);
    bus(1'b1, 8'h27, 8'h20);
    bus(1'b1, 8'h28, 8'h33);
    foreach (rx[i]) begin
      bus(1'b1, 8'h31, rx[i][15:8]);
      remote_station_inst.frame({rx[i][23:16], 8'h33, 8'h60 + 8'(i)});
      repeat (4) @(posedge mclk);
      bus(1'b0, 8'h34, 8'h00);
      chk(q[3], rx[i][0]);
      if (i == 0) begin
        bus(1'b0, 8'h2a, 8'h00);
        chk(q, 8'h03);
      end
      if (rx[i][0]) begin
        chk(lastCtrl, 8'h60 + 8'(i));
        bus(1'b0, 8'h29, 8'h00);
        chk(q, 8'h60 + 8'(i));
      end
    end
    $display("receive address done");
    bus(1'b1, 8'h30, 8'h40);
    remote_station_inst.frame(24'h9c1122);
    bus(1'b1, 8'h28, 8'hff);
    bus(1'b0, 8'h28, 8'h00);
    chk(q, 8'h9c);
    bus(1'b1, 8'h30, 8'h80);
    remote_station_inst.frame(24'h107722);
    bus(1'b1, 8'h28, 8'h00);
    bus(1'b0, 8'h28, 8'h00);
    chk(q, 8'h77);
    bus(1'b1, 8'h30, 8'hc0);
    for (int b = 7; b >= 0; b--) begin
      rxD <= extByte[b];
      rxBv <= 1'b1;
      @(posedge mclk);
      rxBv <= 1'b0;
      @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
    bus(1'b0, 8'h28, 8'h00);
    chk(q, extByte);
    $display("transparent done");
    foreach (tm[i]) begin
      bus(1'b1, 8'h30, tm[i][31:24]);
      bus(1'b1, 8'h23, tm[i][23:16]);
      gap(g);
      chk(16'(g), tm[i][15:0]);
    end
    $display("timer done");
    arst_n <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    chk({wbAck, dmaReq, txByteValid, fifoPush, timerExpired}, 16'h0);
    bus(1'b0, 8'h23, 8'h00);
    chk(q, 8'h00);
    $display("mid-run reset done");
    summarize();
  end
  initial begin
    #400us;
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
